// [omca_pkg.sv]
/*
  Constants, register map and configuration types for the output macrocell array.
  Assumes an APB master on the same clock and an AND array outside that supplies
  the product terms.

  // Notes on behaviour
  // RL1: Twelve macrocells: two with twelve terms, two with ten, eight with eight.
  // RL2: Every macrocell has one extra product term for its output enable.
  // RL3: Output polarity, true or inverted, per macrocell in both modes.
  // RL4: One async clear and one sync set term shared by registered cells.
  // RL5: Async clear term forces registered flip-flops to zero at once.
  // RL6: Sync set term loads one into registered flip-flops next rising edge.
  // RL7: Clear and set act before polarity, so pin level follows polarity.
  // RL8: Mode and polarity come from two configuration bits per macrocell.
  // RL9: Exactly two modes per macrocell: registered and combinatorial I/O.
  // RL10: Registered pin is driven from the flip-flop through the polarity stage.
  // RL11: Registered feedback is inverted flip-flop output, both senses to array.
  // RL12: Registered pin is output only; its level never feeds the array.
  // RL13: Registered output enable follows the macrocell's own enable term.
  // RL14: Combinatorial pin is sum term through polarity, with no register.
  // RL15: Combinatorial enable is always on, always off, or term driven.
  // RL16: Combinatorial feedback comes from the pin, both senses to array.
  // RL17: Registers clear at power-on and can be preloaded for test.
  // RL18: All flip-flops share one clock, on its rising edge.
*/
package omca_pkg;

  localparam int OMCA_CELLS = 12;
  localparam int OMCA_MAX_TERMS = 12;

  // Term counts per cell group; cells 0-1, 2-3, then the rest
  localparam int OMCA_TERMS_WIDE = 12;
  localparam int OMCA_TERMS_MID = 10;
  localparam int OMCA_TERMS_NARROW = 8;
  localparam int OMCA_WIDE_LAST = 1;
  localparam int OMCA_MID_LAST = 3;

  // APB register byte offsets
  localparam logic [11:0] OMCA_MODE_CFG_OFS = 12'h000;
  localparam logic [11:0] OMCA_POLARITY_CFG_OFS = 12'h004;
  localparam logic [11:0] OMCA_OE_CFG_OFS = 12'h008;
  localparam logic [11:0] OMCA_PRELOAD_OFS = 12'h00C;
  localparam logic [11:0] OMCA_STATE_OFS = 12'h010;
  localparam logic [11:0] OMCA_PIN_OFS = 12'h014;

  // Reset values: registered mode, true polarity, enable from product term
  localparam logic [11:0] OMCA_MODE_RST = 12'h000;
  localparam logic [11:0] OMCA_POLARITY_RST = 12'h000;
  localparam logic [23:0] OMCA_OE_RST = 24'h000000;
  localparam logic [11:0] OMCA_STATE_RST = 12'h000;

  // Combinatorial output enable selections, two bits per cell
  localparam logic [1:0] OMCA_OE_TERM = 2'h0;
  localparam logic [1:0] OMCA_OE_ON = 2'h1;
  localparam logic [1:0] OMCA_OE_OFF = 2'h2;

  typedef struct packed {
    logic [1:0] oe_sel;
    logic mode_select_bit_high;
    logic mode_select_bit_low;
  } omca_cell_cfg_t;

  function automatic int omca_term_count(input int idx);
    if (idx <= OMCA_WIDE_LAST) begin
      return OMCA_TERMS_WIDE;
    end else if (idx <= OMCA_MID_LAST) begin
      return OMCA_TERMS_MID;
    end
    return OMCA_TERMS_NARROW;
  endfunction

endpackage

// [omca_macrocell.sv]
/*
  One output macrocell: sum term, D flip-flop, polarity, output enable and feedback.
  Assumes the array supplies product terms synchronous to clk_i; unused term
  inputs above N_TERMS are ignored.
*/
`timescale 1ns/10ps
module omca_macrocell import omca_pkg::*; #(
  parameter int N_TERMS = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clear_i,
  input wire logic set_i,
  input wire logic preload_i,
  input wire logic preload_val_i,
  input wire logic [OMCA_MAX_TERMS-1:0] terms_i,
  input wire logic oe_term_i,
  input wire omca_cell_cfg_t cfg_i,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_o,
  output logic fb_o,
  output logic fb_n_o,
  output logic q_o,
  output logic sum_o
);

  logic q_q;
  logic clr_n;
  logic data;
  logic comb_mode;

  // RL1 term count
  assign sum_o = |terms_i[N_TERMS-1:0];
  // RL9 mode decode
  assign comb_mode = cfg_i.mode_select_bit_high;

  // RL4 shared clear
  // Clear only reaches cells in registered mode; a combinatorial cell keeps its flop
  assign clr_n = reset_n_i & ~(clear_i & ~comb_mode);

  // RL18 common clock
  // RL5 async clear, RL6 sync set, RL17 power-on clear and preload
  always_ff @(posedge clk_i or negedge clr_n) begin
    if (!clr_n) begin
      q_q <= 1'b0;
    end else if (set_i && !comb_mode) begin
      q_q <= 1'b1;
    end else if (preload_i) begin
      q_q <= preload_val_i;
    end else begin
      q_q <= sum_o;
    end
  end

  // RL10 registered data, RL14 combinatorial data
  assign data = comb_mode ? sum_o : q_q;
  // RL3 polarity, RL7 after flop
  assign pin_o = data ^ cfg_i.mode_select_bit_low;

  // RL2 enable term, RL13 registered enable, RL15 combinatorial enable
  always_comb begin
    if (!comb_mode) begin
      pin_oe_o = oe_term_i;
    end else if (cfg_i.oe_sel == OMCA_OE_ON) begin
      pin_oe_o = 1'b1;
    end else if (cfg_i.oe_sel == OMCA_OE_OFF) begin
      pin_oe_o = 1'b0;
    end else begin
      pin_oe_o = oe_term_i;
    end
  end

  // RL11 inverted flop feedback, RL12 pin ignored, RL16 pin feedback
  assign fb_o = comb_mode ? pin_i : ~q_q;
  assign fb_n_o = ~fb_o;
  assign q_o = q_q;

endmodule

// [omca_top.sv]
/*
  Output macrocell array: twelve macrocells, shared clear and set terms, and an
  APB slave holding per-cell mode, polarity, enable selection and test preload.
  Assumes an APB master on clk_i; the AND array and pad logic sit outside.
*/
`timescale 1ns/10ps
module omca_top import omca_pkg::*; (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [OMCA_CELLS-1:0][OMCA_MAX_TERMS-1:0] logic_terms_i,
  input wire logic [OMCA_CELLS-1:0] oe_terms_i,
  input wire logic async_clear_term_i,
  input wire logic sync_set_term_i,
  input wire logic [OMCA_CELLS-1:0] pin_i,
  output logic [OMCA_CELLS-1:0] pin_o,
  output logic [OMCA_CELLS-1:0] pin_oe_o,
  output logic [OMCA_CELLS-1:0] feedback_o,
  output logic [OMCA_CELLS-1:0] feedback_n_o
);

  logic [11:0] mode_comb_q;
  logic [11:0] invert_q;
  logic [23:0] oe_cfg_q;
  logic preload_q;
  logic [11:0] preload_val_q;
  logic [31:0] prdata_q;
  logic [OMCA_CELLS-1:0] q_all;
  logic [OMCA_CELLS-1:0] sum_all;
  logic [31:0] rd_data;
  logic addr_ok;
  logic wr_ok;
  logic access;
  logic wr_en;
  logic [11:0] pwdata_lo;

  assign access = psel_i & penable_i;
  assign pready_o = 1'b1;
  assign pslverr_o = access & (~addr_ok | (pwrite_i & ~wr_ok));
  assign wr_en = access & pwrite_i & addr_ok & wr_ok;
  assign pwdata_lo = pwdata_i[11:0];
  assign prdata_o = prdata_q;

  // Address decode and read mux
  always_comb begin
    rd_data = 32'h00000000;
    addr_ok = 1'b1;
    wr_ok = 1'b1;
    unique case (paddr_i)
      OMCA_MODE_CFG_OFS: begin
        rd_data = {20'h00000, mode_comb_q};
      end
      OMCA_POLARITY_CFG_OFS: begin
        rd_data = {20'h00000, invert_q};
      end
      OMCA_OE_CFG_OFS: begin
        rd_data = {8'h00, oe_cfg_q};
      end
      OMCA_PRELOAD_OFS: begin
        rd_data = {20'h00000, preload_val_q};
      end
      OMCA_STATE_OFS: begin
        rd_data = {20'h00000, q_all};
        wr_ok = 1'b0;
      end
      OMCA_PIN_OFS: begin
        rd_data = {20'h00000, pin_i};
        wr_ok = 1'b0;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // Read data is captured in the setup phase, so state reads lag by one cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_q <= 32'h00000000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_q <= rd_data;
    end
  end

  // RL8 mode and polarity bits
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_comb_q <= OMCA_MODE_RST;
      invert_q <= OMCA_POLARITY_RST;
    end else if (wr_en && paddr_i == OMCA_MODE_CFG_OFS) begin
      mode_comb_q <= pwdata_i[11:0];
    end else if (wr_en && paddr_i == OMCA_POLARITY_CFG_OFS) begin
      invert_q <= pwdata_i[11:0];
    end
  end

  // RL15 enable selection
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      oe_cfg_q <= OMCA_OE_RST;
    end else if (wr_en && paddr_i == OMCA_OE_CFG_OFS) begin
      oe_cfg_q <= pwdata_i[23:0];
    end
  end

  // RL17 preload strobe
  // The write only arms a one-cycle strobe; the cells load on the following edge
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      preload_q <= 1'b0;
      preload_val_q <= OMCA_STATE_RST;
    end else begin
      preload_q <= wr_en && paddr_i == OMCA_PRELOAD_OFS;
      if (wr_en && paddr_i == OMCA_PRELOAD_OFS) begin
        preload_val_q <= pwdata_i[11:0];
      end
    end
  end

  // RL1 cell array, RL4 shared terms
  for (genvar k = 0; k < OMCA_CELLS; k++) begin : g_cell
    omca_cell_cfg_t cfg;
    assign cfg = {oe_cfg_q[2*k+1 -: 2], mode_comb_q[k], invert_q[k]};

    omca_macrocell #(
      .N_TERMS(omca_term_count(k))
    ) u_cell (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .clear_i(async_clear_term_i),
      .set_i(sync_set_term_i),
      .preload_i(preload_q),
      .preload_val_i(preload_val_q[k]),
      .terms_i(logic_terms_i[k]),
      .oe_term_i(oe_terms_i[k]),
      .cfg_i(cfg),
      .pin_i(pin_i[k]),
      .pin_o(pin_o[k]),
      .pin_oe_o(pin_oe_o[k]),
      .fb_o(feedback_o[k]),
      .fb_n_o(feedback_n_o[k]),
      .q_o(q_all[k]),
      .sum_o(sum_all[k])
    );

    cell_enable_a: assert property ( // RL2
      @(posedge clk_i) disable iff (!reset_n_i)
      (!cfg.mode_select_bit_high || (cfg.oe_sel != OMCA_OE_ON && cfg.oe_sel != OMCA_OE_OFF)) |->
        (pin_oe_o[k] == oe_terms_i[k]))
      else $error("enable term not driving output enable");
  end

  clear_forces_zero_a: assert property ( // RL5
    @(posedge clk_i) disable iff (!reset_n_i)
    async_clear_term_i |-> ((q_all & ~mode_comb_q) == 12'h000))
    else $error("registered flop not zero while clear term is true");

  sync_set_ones_a: assert property ( // RL6
    @(posedge clk_i) disable iff (!reset_n_i)
    (sync_set_term_i && !async_clear_term_i) |=>
      (async_clear_term_i || ((q_all | $past(mode_comb_q)) == 12'hFFF)))
    else $error("registered flop did not load one after set term");

  reg_pin_polarity_a: assert property ( // RL7
    @(posedge clk_i) disable iff (!reset_n_i)
    async_clear_term_i |-> (((pin_o ^ invert_q) & ~mode_comb_q) == 12'h000))
    else $error("cleared registered pin does not follow polarity");

  reg_pin_drive_a: assert property ( // RL10
    @(posedge clk_i) disable iff (!reset_n_i)
    ((pin_o ^ invert_q) & ~mode_comb_q) == (q_all & ~mode_comb_q))
    else $error("registered pin not driven from flop");

  comb_pin_drive_a: assert property ( // RL14
    @(posedge clk_i) disable iff (!reset_n_i)
    ((pin_o ^ invert_q) & mode_comb_q) == (sum_all & mode_comb_q))
    else $error("combinatorial pin not driven from sum term");

  term_counts_a: assert property ( // RL1
    @(posedge clk_i) disable iff (!reset_n_i)
    sum_all[0] == (|logic_terms_i[0][11:0]) &&
    sum_all[2] == (|logic_terms_i[2][9:0]) &&
    sum_all[11] == (|logic_terms_i[11][7:0]))
    else $error("sum term uses wrong number of product terms");

  reg_enable_a: assert property ( // RL13
    @(posedge clk_i) disable iff (!reset_n_i)
    (pin_oe_o & ~mode_comb_q) == (oe_terms_i & ~mode_comb_q))
    else $error("registered enable not from enable term");

  comb_enable_a: assert property ( // RL15
    @(posedge clk_i) disable iff (!reset_n_i)
    (mode_comb_q[4] && oe_cfg_q[9:8] == OMCA_OE_ON |-> pin_oe_o[4]) and
    (mode_comb_q[4] && oe_cfg_q[9:8] == OMCA_OE_OFF |-> !pin_oe_o[4]) and
    (mode_comb_q[4] && oe_cfg_q[9:8] == OMCA_OE_TERM |-> pin_oe_o[4] == oe_terms_i[4]))
    else $error("combinatorial enable selection not honoured");

  reg_feedback_a: assert property ( // RL11
    @(posedge clk_i) disable iff (!reset_n_i)
    ((feedback_o & ~mode_comb_q) == (~q_all & ~mode_comb_q)) &&
    (feedback_n_o == ~feedback_o))
    else $error("registered feedback not inverted flop output");

  reg_pin_isolated_a: assert property ( // RL12
    @(posedge clk_i) disable iff (!reset_n_i)
    (!mode_comb_q[0] && $changed(pin_i[0]) && $stable(q_all[0])) |-> $stable(feedback_o[0]))
    else $error("registered pin level reached the array");

  comb_feedback_a: assert property ( // RL16
    @(posedge clk_i) disable iff (!reset_n_i)
    ((feedback_o & mode_comb_q) == (pin_i & mode_comb_q)))
    else $error("combinatorial feedback not from pin");

  preload_load_a: assert property ( // RL17
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_en && paddr_i == OMCA_PRELOAD_OFS) ##1 !sync_set_term_i |=>
      (async_clear_term_i || q_all == $past(pwdata_lo, 2)))
    else $error("preload value not loaded into flops");

  power_on_clear_a: assert property ( // RL17
    @(posedge clk_i) disable iff (!reset_n_i)
    $rose(reset_n_i) |->
      (q_all == OMCA_STATE_RST) && (mode_comb_q == OMCA_MODE_RST) &&
      (invert_q == OMCA_POLARITY_RST) && (oe_cfg_q == OMCA_OE_RST))
    else $error("registers not at reset values after reset");

  mode_write_a: assert property ( // RL8
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_en && paddr_i == OMCA_MODE_CFG_OFS) |=> (mode_comb_q == $past(pwdata_lo)))
    else $error("mode bits not taken from write");

  polarity_write_a: assert property ( // RL8
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_en && paddr_i == OMCA_POLARITY_CFG_OFS) |=> (invert_q == $past(pwdata_lo)))
    else $error("polarity bits not taken from write");

  oe_sel_write_a: assert property ( // RL15
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_en && paddr_i == OMCA_OE_CFG_OFS) |=> (oe_cfg_q == $past(pwdata_i[23:0])))
    else $error("enable selection not taken from write");

  config_hold_a: assert property ( // RL8
    @(posedge clk_i) disable iff (!reset_n_i)
    !wr_en |=>
      ($stable(mode_comb_q) && $stable(invert_q) && $stable(oe_cfg_q)))
    else $error("configuration changed without a write");

  preload_strobe_a: assert property ( // RL17
    @(posedge clk_i) disable iff (!reset_n_i)
    preload_q == $past(wr_en && paddr_i == OMCA_PRELOAD_OFS))
    else $error("preload strobe not one cycle after write");

  mode_read_a: assert property ( // RL8
    @(posedge clk_i) disable iff (!reset_n_i)
    (psel_i && !penable_i && !pwrite_i && paddr_i == OMCA_MODE_CFG_OFS) |=>
      (prdata_o == {20'h00000, $past(mode_comb_q)}))
    else $error("mode read data wrong");

  polarity_read_a: assert property ( // RL3
    @(posedge clk_i) disable iff (!reset_n_i)
    (psel_i && !penable_i && !pwrite_i && paddr_i == OMCA_POLARITY_CFG_OFS) |=>
      (prdata_o == {20'h00000, $past(invert_q)}))
    else $error("polarity read data wrong");

  oe_read_a: assert property ( // RL15
    @(posedge clk_i) disable iff (!reset_n_i)
    (psel_i && !penable_i && !pwrite_i && paddr_i == OMCA_OE_CFG_OFS) |=>
      (prdata_o == {8'h00, $past(oe_cfg_q)}))
    else $error("enable selection read data wrong");

  state_read_a: assert property ( // RL17
    @(posedge clk_i) disable iff (!reset_n_i)
    (psel_i && !penable_i && !pwrite_i && paddr_i == OMCA_STATE_OFS) |=>
      (prdata_o == {20'h00000, $past(q_all)}))
    else $error("state read data wrong");

  pin_read_a: assert property ( // RL16
    @(posedge clk_i) disable iff (!reset_n_i)
    (psel_i && !penable_i && !pwrite_i && paddr_i == OMCA_PIN_OFS) |=>
      (prdata_o == {20'h00000, $past(pin_i)}))
    else $error("pin read data wrong");

  unmapped_read_a: assert property ( // RL8
    @(posedge clk_i) disable iff (!reset_n_i)
    (psel_i && !penable_i && !pwrite_i && !addr_ok) |=> (prdata_o == 32'h00000000))
    else $error("unmapped read not zero");

  ready_zero_wait_a: assert property ( // RL8
    @(posedge clk_i) disable iff (!reset_n_i)
    (psel_i && penable_i) |-> pready_o)
    else $error("access phase without ready");

  refused_write_a: assert property ( // RL8
    @(posedge clk_i) disable iff (!reset_n_i)
    (psel_i && penable_i && pwrite_i &&
      (paddr_i == OMCA_STATE_OFS || paddr_i == OMCA_PIN_OFS)) |-> (pslverr_o && !wr_en))
    else $error("write to read-only register not refused");

  upper_bits_zero_a: assert property ( // RL8
    @(posedge clk_i) disable iff (!reset_n_i)
    (psel_i && penable_i && !pwrite_i) |-> (prdata_o[31:24] == 8'h00))
    else $error("unused read bits not zero");

  comb_flop_sum_a: assert property ( // RL4
    @(posedge clk_i) disable iff (!reset_n_i)
    !preload_q |=>
      (((q_all ^ $past(sum_all)) & mode_comb_q & $past(mode_comb_q)) == 12'h000))
    else $error("shared term reached a combinatorial cell");

endmodule

// [omca_board.sv]
/*
  Board model around the macrocell pins: resolves each pin wire.
  Assumes pull-ups on every pin and one optional external driver.
*/
`timescale 1ns/10ps
module omca_board (
  input wire logic [11:0] pin_o_i,
  input wire logic [11:0] pin_oe_i,
  input wire logic ext_en_i,
  input wire logic [11:0] ext_val_i,
  output logic [11:0] pin_lvl_o
);
  // A released pin takes ext_val_i when ext_en_i is set, else the pull-up level, and never keeps old data
  always_comb begin
    for (int k = 0; k < 12; k++) begin
      pin_lvl_o[k] = pin_oe_i[k] ? pin_o_i[k] : (ext_en_i ? ext_val_i[k] : 1'b1);
    end
  end
endmodule

// [output_macrocell_array_test.sv]
/*
  Self-checking bench for the output macrocell array, driven over APB.
  Assumes omca_top as the design and omca_board resolving the pin wires.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module output_macrocell_array_test import omca_pkg::*; ;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [OMCA_CELLS-1:0][OMCA_MAX_TERMS-1:0] terms = '0;
  logic [OMCA_CELLS-1:0][OMCA_MAX_TERMS-1:0] nt;
  logic [11:0] oe_terms = 12'h000;
  logic [11:0] ext_val = 12'h000;
  logic [11:0] pin_i, pin_o, pin_oe_o, fb, fb_n;
  logic ext_en = 1'b0;
  logic clr = 1'b0;
  logic set = 1'b0;
  logic [31:0] rd;
  logic err;
  logic [1:0] c;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int n;

  always #5 clk_i = ~clk_i;

  omca_top uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .logic_terms_i(terms), .oe_terms_i(oe_terms), .async_clear_term_i(clr),
    .sync_set_term_i(set), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .feedback_o(fb), .feedback_n_o(fb_n));

  omca_board board (.pin_o_i(pin_o), .pin_oe_i(pin_oe_o), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pin_lvl_o(pin_i));

  function automatic int cnt(input int k);
    return k < 2 ? 12 : (k < 4 ? 10 : 8);
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic final_report();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Whole run needs under a hundred cycles; a hang ends here
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    repeat (4) @(posedge clk_i);
    #1;
    `CHK(fb, 12'hFFF)
    `CHK(pin_oe_o, oe_terms)
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (n = 0; n < 5; n++) begin
      if (n != 3) begin
        apb(1'b0, 12'(n * 4), 32'h0);
        `CHK(rd, 32'h0000_0000)
      end
    end
    $display("test reset done");
    nt = '0;
    for (n = 0; n < 12; n++) nt[n][cnt(n)-1] = 1'b1;
    @(posedge clk_i);
    terms <= nt;
    @(posedge clk_i);
    #1;
    `CHK(fb_n, 12'hFFF)
    `CHK(pin_o, 12'hFFF)
    `CHK(fb, 12'h000)
    nt = '0;
    for (n = 0; n < 12; n++) if (cnt(n) < 12) nt[n][cnt(n)] = 1'b1;
    @(posedge clk_i);
    terms <= nt;
    oe_terms <= 12'h0F0;
    ext_en <= 1'b1;
    @(posedge clk_i);
    #1;
    `CHK(fb_n, 12'h000)
    `CHK(pin_oe_o, 12'h0F0)
    `CHK(fb, 12'hFFF)
    $display("test registered done");
    @(posedge clk_i);
    set <= 1'b1;
    #1;
    `CHK(fb_n, 12'h000)
    @(posedge clk_i);
    #1;
    `CHK(fb_n, 12'hFFF)
    apb(1'b0, OMCA_STATE_OFS, 32'h0);
    `CHK(rd, 32'h0000_0FFF)
    apb(1'b1, OMCA_POLARITY_CFG_OFS, 32'h0000_0FFF);
    #1;
    `CHK(pin_o, 12'h000)
    @(posedge clk_i);
    clr <= 1'b1;
    #1;
    `CHK(fb_n, 12'h000)
    `CHK(pin_o, 12'hFFF)
    @(posedge clk_i);
    clr <= 1'b0;
    set <= 1'b0;
    terms <= '0;
    $display("test clear set done");
    apb(1'b1, OMCA_PRELOAD_OFS, 32'h0000_0A5A);
    @(posedge clk_i);
    #1;
    `CHK(fb_n, 12'hA5A)
    `CHK(pin_o, 12'h5A5)
    apb(1'b0, OMCA_PRELOAD_OFS, 32'h0);
    `CHK(rd, 32'h0000_0A5A)
    $display("test preload done");
    apb(1'b1, OMCA_MODE_CFG_OFS, 32'h0000_0FFF);
    apb(1'b1, OMCA_POLARITY_CFG_OFS, 32'h0);
    nt = '0;
    for (n = 0; n < 12; n++) nt[n][0] = n[0];
    @(posedge clk_i);
    terms <= nt;
    #1;
    `CHK(pin_o, 12'hAAA)
    apb(1'b1, OMCA_POLARITY_CFG_OFS, 32'h0000_0FFF);
    #1;
    `CHK(pin_o, 12'h555)
    for (n = 0; n < 4; n++) begin
      c = n[1:0];
      apb(1'b1, OMCA_OE_CFG_OFS, {8'h00, {12{c}}});
      #1;
      `CHK(pin_oe_o, c == 2'h1 ? 12'hFFF : (c == 2'h2 ? 12'h000 : 12'h0F0))
    end
    apb(1'b1, OMCA_OE_CFG_OFS, {8'h00, {12{OMCA_OE_OFF}}});
    @(posedge clk_i);
    ext_val <= 12'h3C3;
    #1;
    `CHK(fb, 12'h3C3)
    `CHK(fb_n, 12'hC3C)
    apb(1'b0, OMCA_PIN_OFS, 32'h0);
    `CHK(rd, 32'h0000_03C3)
    $display("test combinatorial done");
    apb(1'b0, 12'h018, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    apb(1'b1, OMCA_STATE_OFS, 32'h0000_0FFF);
    `CHK(err, 1'b1)
    $display("test refusal done");
    final_report();
  end
endmodule
